// ### core/sdci_top.sv
// Command, address and data-mask interface of one dual-bank by-16 synchronous DRAM die
//
// What this block does
// R01 - Every pin is sampled only on the rising clock edge.
// R02 - Clock gate high runs; low enters power-down, suspend or self refresh.
// R03 - Deselected die ignores new commands; running bursts continue.
// R04 - Operation decoded from the three strobes while selected.
// R05 - Bank pick low addresses bank A, high addresses bank B.
// R06 - Activate latches the 11-bit row for the picked bank.
// R07 - Read or write latches the column address for the picked bank.
// R08 - By-16 organisation ignores column bits eight and nine.
// R09 - Address bit ten on read or write requests auto-precharge after the burst.
// R10 - Precharge with bit ten closes both banks, else the picked one.
// R11 - Read mask forces lanes off two cycles after sampling.
// R12 - Write mask acts in the same cycle and drops masked lanes.
// R13 - Two independent byte masks, one per data lane.
// R14 - Read latency programmable to one, two or three cycles.
// R15 - Burst length one, two, four, eight or full page.
// R16 - Burst order sequential wrap or interleaved wrap.
// R17 - Controller programs latency, length and order by mode set before access.
// R18 - Option: reads burst, every write moves a single word.
// R19 - Auto and self refresh; 4096 refreshes needed every 64 ms.
// R20 - Only self refresh may target both stacked decks together.
// R21 - Each deck select acts as that die's chip select.
// R22 - A new random column is accepted every clock within an open row.
// R23 - Mode set is all strobes low; next command on the second clock.
// R24 - Controller waits, precharges both banks, refreshes twice, then sets mode.
// R25 - Banks precharged and clock gate high a cycle before mode set.
// R26 - Remaining commands follow the customary strobe truth table.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "sdci_map.svh"

module sdci_top #(
   parameter int unsigned REFRESH_WINDOW_CYCLES = `SDCI_REF_WINDOW_MS * 1000 * `SDCI_CLOCK_MHZ
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clockGateIn,
   input wire logic selectN,
   input wire logic lowerDeckSelectN,
   input wire logic upperDeckSelectN,
   input wire logic deckStrap,
   input wire logic rowStrobeN,
   input wire logic columnStrobeN,
   input wire logic writeStrobeN,
   input wire logic [`SDCI_ADDR_W-1:0] addrIn,
   input wire logic bankPick,
   input wire logic lowByteMask,
   input wire logic highByteMask,
   input wire logic [`SDCI_DATA_W-1:0] dataIn,
   output logic [`SDCI_DATA_W-1:0] dataOut,
   output logic [`SDCI_LANES-1:0] dataOe,
   output logic [1:0] bankOpen,
   output logic selfRefreshActive,
   output logic powerDownActive,
   output logic refreshOverdue
);
   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic sdci_pkg::sdci_cmd_t decodeCmd(input logic r, input logic c,
                                                     input logic w);
      unique case ({r, c, w})
         3'h0: decodeCmd = sdci_pkg::CMD_MRS;
         3'h1: decodeCmd = sdci_pkg::CMD_REF;
         3'h2: decodeCmd = sdci_pkg::CMD_PRE;
         3'h3: decodeCmd = sdci_pkg::CMD_ACT;
         3'h4: decodeCmd = sdci_pkg::CMD_WRITE;
         3'h5: decodeCmd = sdci_pkg::CMD_READ;
         3'h6: decodeCmd = sdci_pkg::CMD_STOP;
         3'h7: decodeCmd = sdci_pkg::CMD_NOP;
      endcase
   endfunction : decodeCmd

   function automatic logic [`SDCI_LEN_W-1:0] burstLen(input logic [2:0] code);
      unique case (code)
         `SDCI_BL2: burstLen = `SDCI_LEN2;
         `SDCI_BL4: burstLen = `SDCI_LEN4;
         `SDCI_BL8: burstLen = `SDCI_LEN8;
         `SDCI_BLPAGE: burstLen = `SDCI_LENPAGE;
         default: burstLen = `SDCI_LEN1;
      endcase
   endfunction : burstLen

   // Column of the idx-th beat: wraps inside the burst-sized block
   function automatic logic [`SDCI_COL_W-1:0] burstCol(input logic [`SDCI_COL_W-1:0] base,
                                                       input logic [`SDCI_COL_W-1:0] idx,
                                                       input logic [2:0] code,
                                                       input logic interleave);
      logic [`SDCI_COL_W-1:0] wrapMask;
      wrapMask = 8'(burstLen(code) - `SDCI_LEN1);
      if (interleave) begin
         burstCol = (base & ~wrapMask) | ((base ^ idx) & wrapMask); // R16
      end else begin
         burstCol = (base & ~wrapMask) | (8'(base + idx) & wrapMask); // R16
      end
   endfunction : burstCol

   // ----------------------------------------------------------------
   // Deck strap, selection and command decode
   // ----------------------------------------------------------------
   logic deckUpper_q;
   logic [`SDCI_MR_W-1:0] mode_q;
   logic mrsHold_q;
   sdci_pkg::sdci_pwr_t pwr_q;
   logic burstActive_q;
   logic burstWrite_q;
   logic burstBank_q;
   logic burstAp_q;
   logic [`SDCI_COL_W-1:0] burstBase_q;
   logic [`SDCI_COL_W-1:0] burstIdx_q;
   logic [`SDCI_LEN_W-1:0] burstLeft_q;
   logic [`SDCI_ADDR_W-1:0] openRow_q [2];
   logic [1:0] bankOpen_q;

   // Strap caught while reset is held; planar parts tie both deck selects low
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         deckUpper_q <= deckStrap;
      end
   end

   logic selected;
   logic cmdLive;
   sdci_pkg::sdci_cmd_t cmdRaw;
   sdci_pkg::sdci_cmd_t cmd;
   assign selected = !selectN && (deckUpper_q ? !upperDeckSelectN : !lowerDeckSelectN); // R21
   assign cmdRaw = decodeCmd(rowStrobeN, columnStrobeN, writeStrobeN); // R04 R26
   // Commands need a running clock, selection and the gap after a mode set
   assign cmdLive = selected && clockGateIn && pwr_q == sdci_pkg::PWR_RUN && !mrsHold_q; // R03 R23
   assign cmd = cmdLive ? cmdRaw : sdci_pkg::CMD_NOP;

   logic actFire, readFire, writeFire, preFire, refFire, mrsFire, stopFire;
   assign actFire = cmd == sdci_pkg::CMD_ACT;
   assign readFire = cmd == sdci_pkg::CMD_READ && bankOpen_q[bankPick];
   assign writeFire = cmd == sdci_pkg::CMD_WRITE && bankOpen_q[bankPick];
   assign preFire = cmd == sdci_pkg::CMD_PRE;
   assign refFire = cmd == sdci_pkg::CMD_REF;
   assign mrsFire = cmd == sdci_pkg::CMD_MRS;
   assign stopFire = cmd == sdci_pkg::CMD_STOP;

   // ----------------------------------------------------------------
   // Mode register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode_q <= `SDCI_MR_RESET;
      end else if (mrsFire) begin
         mode_q <= addrIn[`SDCI_MR_W-1:0]; // R01 R17 R23
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mrsHold_q <= 1'b0;
      end else begin
         mrsHold_q <= mrsFire; // R23
      end
   end

   logic [2:0] modeCl;
   logic modeSwr;
   assign modeCl = mode_q[`SDCI_MR_CL];
   assign modeSwr = mode_q[`SDCI_MR_SWR];

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pwr_q <= sdci_pkg::PWR_RUN;
      end else begin
         unique case (pwr_q)
            sdci_pkg::PWR_RUN: begin
               if (!clockGateIn) begin // R02
                  if (selected && cmdRaw == sdci_pkg::CMD_REF && !burstActive_q) begin
                     pwr_q <= sdci_pkg::PWR_SELFREF; // R19
                  end else if (burstActive_q) begin
                     pwr_q <= sdci_pkg::PWR_SUSPEND;
                  end else begin
                     pwr_q <= sdci_pkg::PWR_DOWN;
                  end
               end
            end
            sdci_pkg::PWR_DOWN, sdci_pkg::PWR_SUSPEND, sdci_pkg::PWR_SELFREF: begin
               if (clockGateIn) begin
                  pwr_q <= sdci_pkg::PWR_RUN; // R02
               end
            end
         endcase
      end
   end

   assign selfRefreshActive = pwr_q == sdci_pkg::PWR_SELFREF;
   assign powerDownActive = pwr_q == sdci_pkg::PWR_DOWN || pwr_q == sdci_pkg::PWR_SUSPEND;

   // ----------------------------------------------------------------
   // Bursts: a new column every clock, wrapped by length and order
   // ----------------------------------------------------------------
   logic clkRun;
   logic contAccess;
   logic accessBank;
   logic [`SDCI_COL_W-1:0] accessCol;
   logic lastBeat;
   assign clkRun = clockGateIn && pwr_q == sdci_pkg::PWR_RUN; // R02
   // A deselected die keeps clocking out the burst it already started
   assign contAccess = burstActive_q && clkRun && !readFire && !writeFire && !stopFire
                       && !(preFire && (addrIn[`SDCI_AP_BIT] || bankPick == burstBank_q)); // R03
   assign accessBank = (readFire || writeFire) ? bankPick : burstBank_q; // R05
   assign accessCol = (readFire || writeFire) ? addrIn[`SDCI_COL_W-1:0] // R07 R08
                    : burstCol(burstBase_q, burstIdx_q, mode_q[`SDCI_MR_BL], mode_q[`SDCI_MR_WRAP]);
   // Full-page bursts never end on their own
   assign lastBeat = contAccess && burstLeft_q == `SDCI_LEN1 && mode_q[`SDCI_MR_BL] != `SDCI_BLPAGE;

   logic [`SDCI_LEN_W-1:0] newLen;
   always_comb begin
      newLen = burstLen(mode_q[`SDCI_MR_BL]); // R15
      if (writeFire && modeSwr) begin
         newLen = `SDCI_LEN1; // R18
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         burstActive_q <= 1'b0;
         burstWrite_q <= 1'b0;
         burstBank_q <= 1'b0;
         burstAp_q <= 1'b0;
         burstBase_q <= '0;
         burstIdx_q <= '0;
         burstLeft_q <= '0;
      end else if (readFire || writeFire) begin // R22
         burstActive_q <= newLen != `SDCI_LEN1;
         burstWrite_q <= writeFire;
         burstBank_q <= bankPick;
         burstAp_q <= addrIn[`SDCI_AP_BIT]; // R09
         burstBase_q <= addrIn[`SDCI_COL_W-1:0];
         burstIdx_q <= 8'h01;
         burstLeft_q <= newLen - `SDCI_LEN1;
      end else if (contAccess) begin
         burstActive_q <= !lastBeat;
         burstIdx_q <= burstIdx_q + 8'h01;
         burstLeft_q <= burstLeft_q - `SDCI_LEN1;
      end else if (clkRun && burstActive_q) begin
         burstActive_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bank rows: activate, precharge and auto-precharge
   // ----------------------------------------------------------------
   logic apClose;
   logic apBank;
   assign apClose = ((readFire || writeFire) && addrIn[`SDCI_AP_BIT] && newLen == `SDCI_LEN1)
                    || (lastBeat && burstAp_q); // R09
   assign apBank = (readFire || writeFire) ? bankPick : burstBank_q;

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : gBank
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               bankOpen_q[b] <= 1'b0;
               openRow_q[b] <= '0;
            end else if (actFire && bankPick == b[0]) begin
               bankOpen_q[b] <= 1'b1; // R05 R06
               openRow_q[b] <= addrIn; // R06
            end else if (preFire && (addrIn[`SDCI_AP_BIT] || bankPick == b[0])) begin
               bankOpen_q[b] <= 1'b0; // R10
            end else if (apClose && apBank == b[0]) begin
               bankOpen_q[b] <= 1'b0; // R09
            end
         end
      end
   endgenerate
   assign bankOpen = bankOpen_q;

   // ----------------------------------------------------------------
   // Cell array access
   // ----------------------------------------------------------------
   logic readAccess;
   logic writeAccess;
   logic [`SDCI_MEM_AW-1:0] memAddr;
   logic [`SDCI_LANES-1:0] laneEn;
   logic [`SDCI_DATA_W-1:0] memData;
   assign readAccess = readFire || (contAccess && !burstWrite_q);
   assign writeAccess = writeFire || (contAccess && burstWrite_q);
   // Only the low row bits reach the cells; higher rows alias in this model
   assign memAddr = {accessBank, openRow_q[accessBank][`SDCI_MEM_ROW_W-1:0], accessCol};
   assign laneEn = ~{highByteMask, lowByteMask}; // R12 R13

   sdci_mem uMem (
      .clock(clock),
      .writeEn(writeAccess),
      .writeAddr(memAddr),
      .writeData(dataIn),
      .laneEn(laneEn),
      .readEn(readAccess),
      .readAddr(memAddr),
      .readData_q(memData)
   );

   // ----------------------------------------------------------------
   // Read latency and output mask pipelines
   // ----------------------------------------------------------------
   logic rdValid0_q, rdValid1_q, rdValid2_q;
   logic [`SDCI_DATA_W-1:0] rdData1_q, rdData2_q;
   logic [`SDCI_LANES-1:0] maskPipe1_q, maskPipe2_q;

   // Pipelines freeze with the clock gate so a suspended burst resumes intact
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rdValid0_q <= 1'b0;
         rdValid1_q <= 1'b0;
         rdValid2_q <= 1'b0;
         rdData1_q <= '0;
         rdData2_q <= '0;
      end else if (clockGateIn) begin
         rdValid0_q <= readAccess; // R14
         rdValid1_q <= rdValid0_q;
         rdValid2_q <= rdValid1_q;
         rdData1_q <= memData;
         rdData2_q <= rdData1_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         maskPipe1_q <= '1;
         maskPipe2_q <= '1;
      end else if (clockGateIn) begin
         maskPipe1_q <= {highByteMask, lowByteMask}; // R11 R13
         maskPipe2_q <= maskPipe1_q; // R11
      end
   end

   logic rdValid;
   always_comb begin
      unique case (modeCl)
         `SDCI_CL1: begin
            rdValid = rdValid0_q; // R14
            dataOut = memData;
         end
         `SDCI_CL2: begin
            rdValid = rdValid1_q; // R14
            dataOut = rdData1_q;
         end
         default: begin
            rdValid = rdValid2_q; // R14
            dataOut = rdData2_q;
         end
      endcase
   end
   assign dataOe = {`SDCI_LANES{rdValid}} & ~maskPipe2_q; // R11

   // ----------------------------------------------------------------
   // Refresh bookkeeping
   // ----------------------------------------------------------------
   logic [`SDCI_TIMER_W-1:0] windowTimer_q;
   logic [12:0] refreshCount_q;
   logic refreshOverdue_q;
   logic windowEnd;
   assign windowEnd = windowTimer_q == `SDCI_TIMER_W'(REFRESH_WINDOW_CYCLES - 1);

   // Self refresh keeps the cells alive, so each cycle in it counts as one refresh
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         windowTimer_q <= '0;
         refreshCount_q <= '0;
      end else if (windowEnd) begin
         windowTimer_q <= '0;
         refreshCount_q <= '0;
      end else begin
         windowTimer_q <= windowTimer_q + `SDCI_TIMER_W'(1);
         if ((refFire || selfRefreshActive) && refreshCount_q != `SDCI_REF_NEEDED) begin
            refreshCount_q <= refreshCount_q + 13'h0001; // R19
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         refreshOverdue_q <= 1'b0;
      end else if (windowEnd && refreshCount_q != `SDCI_REF_NEEDED) begin
         refreshOverdue_q <= 1'b1; // R19
      end
   end
   assign refreshOverdue = refreshOverdue_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_read_lat_one: assert property (readFire && modeCl == `SDCI_CL1 |=> rdValid) // R14
      else $error("read data not valid one cycle after read");
   a_read_lat_three: assert property ((readFire && modeCl == `SDCI_CL3 && !mrsFire)
      ##1 clockGateIn[*2] |=> rdValid && dataOut == rdData2_q) // R14
      else $error("read data not valid three cycles after read");
   a_mask_read: assert property (lowByteMask && clockGateIn ##1 clockGateIn |=> !dataOe[0]) // R11
      else $error("read mask did not blank low lane after two cycles");
   a_write_mask: assert property (writeAccess |-> laneEn[1] == !highByteMask) // R12
      else $error("high lane write enable not tied to its mask");
   a_act_opens: assert property (actFire |=> bankOpen[$past(bankPick)]) // R06
      else $error("activate did not open the picked bank");
   a_pre_all: assert property (preFire && addrIn[`SDCI_AP_BIT] |=> bankOpen == 2'h0) // R10
      else $error("precharge all left a bank open");
   a_deselect_hold: assert property (selectN && !burstActive_q && !actFire
      |=> bankOpen == $past(bankOpen)) // R03
      else $error("deselected die changed bank state");
   a_single_write: assert property (writeFire && modeSwr |=> !burstActive_q) // R18
      else $error("single-write mode started a write burst");
   a_mrs_gap: assert property (mrsFire |=> !cmdLive ##1 (selected && clockGateIn
      && pwr_q == sdci_pkg::PWR_RUN) |-> cmdLive) // R23
      else $error("command gap after mode set is wrong");
   a_self_ref: assert property (pwr_q == sdci_pkg::PWR_RUN && !clockGateIn && selected
      && cmdRaw == sdci_pkg::CMD_REF && !burstActive_q |=> selfRefreshActive) // R02 R19
      else $error("self refresh not entered");

   c_read_burst: cover property (readFire ##1 contAccess[*3]);
   c_write_burst: cover property (writeFire ##1 contAccess);
   c_self_ref: cover property (selfRefreshActive ##1 !selfRefreshActive);
   c_auto_pre: cover property (apClose);

endmodule : sdci_top

// ### core/sdci_map.svh
// Pin widths, mode word layout, encodings and timing counts of the command interface
`ifndef SDCI_MAP_SVH
`define SDCI_MAP_SVH

`define SDCI_ADDR_W 11
`define SDCI_COL_W 8
`define SDCI_DATA_W 16
`define SDCI_LANES 2
`define SDCI_AP_BIT 10
`define SDCI_MEM_ROW_W 2
`define SDCI_MEM_AW 11

// ----------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------
`define SDCI_MR_W 10
`define SDCI_MR_BL 2:0
`define SDCI_MR_WRAP 3
`define SDCI_MR_CL 6:4
`define SDCI_MR_SWR 9
`define SDCI_MR_RESET 10'h030
`define SDCI_BL1 3'h0
`define SDCI_BL2 3'h1
`define SDCI_BL4 3'h2
`define SDCI_BL8 3'h3
`define SDCI_BLPAGE 3'h7
`define SDCI_CL1 3'h1
`define SDCI_CL2 3'h2
`define SDCI_CL3 3'h3
`define SDCI_LEN_W 9
`define SDCI_LEN1 9'h001
`define SDCI_LEN2 9'h002
`define SDCI_LEN4 9'h004
`define SDCI_LEN8 9'h008
`define SDCI_LENPAGE 9'h100

// ----------------------------------------------------------------
// Refresh bookkeeping
// ----------------------------------------------------------------
`define SDCI_REF_NEEDED 13'h1000
`define SDCI_REF_WINDOW_MS 64
`define SDCI_CLOCK_MHZ 40
`define SDCI_TIMER_W 22

`endif

// ### core/sdci_pkg.sv
// Types shared by the command interface: decoded commands and power states
package sdci_pkg;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS, CMD_STOP
   } sdci_cmd_t;

   typedef enum logic [1:0] {
      PWR_RUN, PWR_DOWN, PWR_SUSPEND, PWR_SELFREF
   } sdci_pwr_t;

endpackage : sdci_pkg

// ### core/sdci_mem.sv
// Small cell array with per-lane write enables and a registered read port
`timescale 1ns/1ps
`include "sdci_map.svh"

module sdci_mem (
   input wire logic clock,
   input wire logic writeEn,
   input wire logic [`SDCI_MEM_AW-1:0] writeAddr,
   input wire logic [`SDCI_DATA_W-1:0] writeData,
   input wire logic [`SDCI_LANES-1:0] laneEn,
   input wire logic readEn,
   input wire logic [`SDCI_MEM_AW-1:0] readAddr,
   output logic [`SDCI_DATA_W-1:0] readData_q
);
   genvar g;
   generate
      for (g = 0; g < `SDCI_LANES; g++) begin : gLane
         // One array per lane, so every cell has a single writing process
         logic [7:0] cells [0:(1<<`SDCI_MEM_AW)-1];
         always_ff @(posedge clock) begin
            if (writeEn && laneEn[g]) begin
               cells[writeAddr] <= writeData[g*8 +: 8];
            end
         end
         // Holding the read register keeps the output steady while the clock is gated
         always_ff @(posedge clock) begin
            if (readEn) begin
               readData_q[g*8 +: 8] <= cells[readAddr];
            end
         end
      end
   endgenerate

endmodule : sdci_mem

// ### dv/sdci_ctrl_model.sv
// Memory controller model that drives the command, address, mask and data pins
`timescale 1ns/1ps
`include "sdci_map.svh"

module sdci_ctrl_model #(
   parameter int INIT_WAIT = 4000
) (
   input wire logic clock,
   output logic clockGateIn,
   output logic selectN,
   output logic rowStrobeN,
   output logic columnStrobeN,
   output logic writeStrobeN,
   output logic [`SDCI_ADDR_W-1:0] addrIn,
   output logic bankPick,
   output logic lowByteMask,
   output logic highByteMask,
   output logic [`SDCI_DATA_W-1:0] dataIn
);
   initial begin
      clockGateIn = 1'h1;
      {selectN, rowStrobeN, columnStrobeN, writeStrobeN} = 4'hF;
      addrIn = 11'h000;
      bankPick = 1'h0;
      {highByteMask, lowByteMask} = 2'h3;
      dataIn = 16'h0000;
   end

   // ----------------------------------------------------------------
   // Command cycles
   // ----------------------------------------------------------------
   // One command, then a selected no-op; the gap also honours the mode set spacing
   task automatic cmd(input logic [3:0] c, input logic [10:0] a, input logic b,
                      input logic [1:0] m, input logic [15:0] d);
      @(posedge clock);
      {selectN, rowStrobeN, columnStrobeN, writeStrobeN} <= c;
      addrIn <= a;
      bankPick <= b;
      {highByteMask, lowByteMask} <= m;
      dataIn <= d;
      @(posedge clock);
      {selectN, rowStrobeN, columnStrobeN, writeStrobeN} <= 4'h7;
      {highByteMask, lowByteMask} <= 2'h0;
      // Released lines show inverted values so stale data cannot pass
      addrIn <= ~a;
      dataIn <= ~d;
   endtask : cmd

   // Clock gate low for n edges with strobes c held on all of them, then running again
   task automatic gate(input logic [3:0] c, input int n);
      @(posedge clock);
      clockGateIn <= 1'h0;
      {selectN, rowStrobeN, columnStrobeN, writeStrobeN} <= c;
      repeat (n) @(posedge clock);
      clockGateIn <= 1'h1;
      {selectN, rowStrobeN, columnStrobeN, writeStrobeN} <= 4'h7;
   endtask : gate

   task automatic init(input logic [9:0] mw, input logic fresh);
      if (fresh)
         repeat (INIT_WAIT) @(posedge clock);
      cmd(4'h2, 11'h400, 1'h0, 2'h0, 16'h0000);
      cmd(4'h1, 11'h000, 1'h0, 2'h0, 16'h0000);
      cmd(4'h1, 11'h000, 1'h0, 2'h0, 16'h0000);
      cmd(4'h0, {1'h0, mw}, 1'h0, 2'h0, 16'h0000);
   endtask : init
endmodule : sdci_ctrl_model

// ### dv/tb_sdci_top.sv
// Self-checking bench for the command interface die
`timescale 1ns/1ps
`include "sdci_map.svh"

module tb_sdci_top;
   localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2;
   logic clock, reset_n, clockGateIn, selectN, rowStrobeN, columnStrobeN, writeStrobeN;
   logic bankPick, lowByteMask, highByteMask, selfRefreshActive, powerDownActive;
   logic refreshOverdue;
   logic [`SDCI_ADDR_W-1:0] addrIn;
   logic [`SDCI_DATA_W-1:0] dataIn, dataOut;
   logic [1:0] dataOe, bankOpen;
   int numErrors, checked;

   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end

   sdci_ctrl_model i_ctrl (.clock(clock), .clockGateIn(clockGateIn), .selectN(selectN),
      .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN),
      .addrIn(addrIn), .bankPick(bankPick), .lowByteMask(lowByteMask),
      .highByteMask(highByteMask), .dataIn(dataIn));

   // Short refresh window keeps the overdue check inside the run
   sdci_top #(.REFRESH_WINDOW_CYCLES(200)) i_dut (.clock(clock), .reset_n(reset_n),
      .clockGateIn(clockGateIn), .selectN(selectN), .lowerDeckSelectN(1'h0),
      .upperDeckSelectN(1'h1), .deckStrap(1'h0), .rowStrobeN(rowStrobeN),
      .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN), .addrIn(addrIn),
      .bankPick(bankPick), .lowByteMask(lowByteMask), .highByteMask(highByteMask),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .bankOpen(bankOpen),
      .selfRefreshActive(selfRefreshActive), .powerDownActive(powerDownActive),
      .refreshOverdue(refreshOverdue));

   // ----------------------------------------------------------------
   // Checking tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic testDone;
      $display("Checks %0d errors %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : testDone

   // Index of the first driven cycle, one being the cycle right after the read edge
   task automatic rdChk(input logic [10:0] a, input logic b, input logic [1:0] m,
                        input int cl, input logic [1:0] oe, input logic [15:0] exp);
      int k;
      k = 1;
      i_ctrl.cmd(RD, a, b, m, 16'h0000);
      #1;
      while (dataOe === 2'h0 && k < 8) begin
         @(posedge clock);
         #1;
         k++;
      end
      chk(16'(k), 16'(cl));
      chk({14'h0, dataOe}, {14'h0, oe});
      chk(dataOut & {{8{oe[1]}}, {8{oe[0]}}}, exp);
      if (dataOe === 2'h0 && oe !== 2'h0)
         testDone();
   endtask : rdChk

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      numErrors = 0;
      checked = 0;
      reset_n = 1'h0;
      repeat (4) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      #1 chk({12'h000, bankOpen, dataOe}, 16'h0000);
      i_ctrl.init(10'h020, 1'h1);
      i_ctrl.cmd(ACT, 11'h005, 1'h1, 2'h0, 16'h0000);
      #1 chk({14'h0, bankOpen}, 16'h0002);
      i_ctrl.cmd(WR, 11'h004, 1'h1, 2'h0, 16'hA55A);
      i_ctrl.cmd(WR, 11'h004, 1'h1, 2'h2, 16'h1234);
      rdChk(11'h304, 1'h1, 2'h0, 2, 2'h3, 16'hA534);
      rdChk(11'h004, 1'h1, 2'h1, 2, 2'h2, 16'hA500);
      i_ctrl.cmd(4'hD, 11'h004, 1'h1, 2'h0, 16'h0000);
      repeat (4) begin
         @(posedge clock);
         #1 chk({14'h0, dataOe}, 16'h0000);
      end
      i_ctrl.cmd(ACT, 11'h001, 1'h0, 2'h0, 16'h0000);
      #1 chk({14'h0, bankOpen}, 16'h0003);
      i_ctrl.cmd(PRE, 11'h000, 1'h1, 2'h0, 16'h0000);
      #1 chk({14'h0, bankOpen}, 16'h0001);
      i_ctrl.cmd(ACT, 11'h005, 1'h1, 2'h0, 16'h0000);
      rdChk(11'h404, 1'h1, 2'h0, 2, 2'h3, 16'hA534);
      repeat (4) @(posedge clock);
      #1 chk({14'h0, bankOpen}, 16'h0001);
      i_ctrl.gate(4'h1, 3);
      #1 chk({14'h0, selfRefreshActive, powerDownActive}, 16'h0002);
      i_ctrl.gate(4'h7, 3);
      #1 chk({14'h0, selfRefreshActive, powerDownActive}, 16'h0001);
      @(posedge clock);
      #1 chk({14'h0, selfRefreshActive, powerDownActive}, 16'h0000);
      for (int cl = 1; cl <= 3; cl++) begin
         i_ctrl.init({3'h0, 3'(cl), 4'h0}, 1'h0);
         #1 chk({14'h0, bankOpen}, 16'h0000);
         i_ctrl.cmd(ACT, 11'h005, 1'h1, 2'h0, 16'h0000);
         rdChk(11'h004, 1'h1, 2'h0, cl, 2'h3, 16'hA534);
      end
      // Four-beat interleaved bursts at latency one; the read cuts the write after two beats
      i_ctrl.init(10'h01A, 1'h0);
      i_ctrl.cmd(ACT, 11'h005, 1'h1, 2'h0, 16'h0000);
      i_ctrl.cmd(WR, 11'h004, 1'h1, 2'h0, 16'h3C96);
      rdChk(11'h005, 1'h1, 2'h0, 1, 2'h3, 16'hC369);
      @(posedge clock);
      #1 chk(dataOut, 16'h3C96);
      chk({15'h0, refreshOverdue}, 16'h0001);
      testDone();
   end
endmodule : tb_sdci_top
